// file: verilog/sdcb_core.sv
// sdcb_core: command interpreter and per-bank state for a ddr dram model
// assumes pin inputs arrive asynchronously and are double registered here
`default_nettype none
// Operation
// - idle cycle registers nothing, bursts continue
// - unselected chip ignores inputs, work completes
// - row open holds row until bank closed
// - fetch starts burst at bank and column
// - bit ten requests close, at burst end for a store only
// - masked store beats leave bytes unchanged
// - close with bit ten closes all banks
// - closed bank idles after precharge period
// - close on idle or closing bank ignored
// - fetch autoclose starts at latency plus delay
// - store autoclose waits for last beat stored
// - autoclose held off until row active minimum
// - renew uses internal row, one per command
// - renew with clock enable low enters self renew
// - self renew disables loop and termination
// - calibration long and short performed when idle
// - calibration runs concurrently with loop lock
// - strobes decoded each rising edge into commands
// - bit twelve selects eight or four beats
module sdcb_core
    import sdcb_pkg::*;
#(
    parameter int ADDITIVE_LATENCY = 0,
    parameter int MEM_AW = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire sdcb_cmd_pins_t cmd_pins,
    input wire logic clk_enable,
    input wire logic [7:0] store_data,
    input wire logic byte_mask,
    output sdcb_access_t fetch_access_q,
    output logic [7:0] fetch_data_q,
    output logic [NUM_BANKS-1:0] bank_open_q,
    output logic [NUM_BANKS*ROW_W-1:0] bank_rows_q,
    output logic [ADDR_W-1:0] mode_value_q,
    output logic [1:0] mode_select_q,
    output logic self_renew_q,
    output logic loop_enabled_q,
    output logic termination_enabled_q,
    output logic calibrating_q,
    output logic [15:0] renew_row_q,
    output logic burst_busy_q
);
    localparam int BEAT_W = 4;

    initial begin
        if (ADDITIVE_LATENCY < 0 || ADDITIVE_LATENCY > 31) $error("additive latency out of range");
        if (MEM_AW < 4 || MEM_AW > 12) $error("memory address width out of range");
    end

    function automatic logic [TIMER_W-1:0] cyc(input int n);
        return n[TIMER_W-1:0];
    endfunction

    // two-stage input synchronisers
    sdcb_cmd_pins_t pins_s1_q, pins_q;
    logic cke_s1_q, cke_q, cke_prev_q;
    logic [7:0] data_s1_q, data_q;
    logic mask_s1_q, mask_q;

    always_ff @(posedge core_clk) begin
        pins_s1_q <= cmd_pins;
        pins_q <= pins_s1_q;
        cke_s1_q <= clk_enable;
        cke_q <= cke_s1_q;
        data_s1_q <= store_data;
        data_q <= data_s1_q;
        mask_s1_q <= byte_mask;
        mask_q <= mask_s1_q;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= cke_q;
        end
    end

    sdcb_cmd_t cmd;
    sdcb_decode u_decode (
        .pins(pins_q),
        .cke_prev(cke_prev_q),
        .cke_now(cke_q),
        .cmd(cmd)
    );

    // self renew ignores everything but clock enable
    logic live;
    assign live = cke_prev_q && cke_q && !self_renew_q;

    logic [BANK_W-1:0] ba;
    logic ap_bit, long_bit;
    assign ba = pins_q.bank_select_inputs;
    assign ap_bit = pins_q.addr[AUTOCLOSE_BIT];
    assign long_bit = pins_q.addr[CHOP_BIT];

    // per-bank state
    sdcb_bank_st_t bank_st_q [NUM_BANKS];
    logic [TIMER_W-1:0] bank_tmr_q [NUM_BANKS];
    logic [TIMER_W-1:0] ras_tmr_q [NUM_BANKS];
    logic ac_pend_q [NUM_BANKS];
    logic [TIMER_W-1:0] ac_tmr_q [NUM_BANKS];

    // write burst tracking
    logic [BEAT_W-1:0] beats_left_q;
    logic [BANK_W-1:0] wr_bank_q;
    logic wr_ac_q;
    logic [MEM_AW-1:0] wr_ptr_q;

    logic [9:0] lock_cnt_q;
    logic store_go, fetch_go, open_go, close_go;
    assign store_go = live && cmd == SDCB_STORE && bank_st_q[ba] == SDCB_BANK_OPEN;
    assign fetch_go = live && cmd == SDCB_FETCH && bank_st_q[ba] == SDCB_BANK_OPEN && lock_cnt_q == 10'h000;
    assign open_go = live && cmd == SDCB_ROW_OPEN && bank_st_q[ba] == SDCB_BANK_IDLE
                     && bank_tmr_q[ba] == TIMER_ZERO;
    assign close_go = live && cmd == SDCB_CLOSE;

    logic wr_last;
    assign wr_last = beats_left_q == 4'h1;

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            logic sel, close_this, ac_fire;
            assign sel = ba == BANK_W'(g);
            // a closing or idle bank treats the close as no work
            assign close_this = close_go && (ap_bit || sel) && bank_st_q[g] == SDCB_BANK_OPEN;
            // autoclose waits for both its own delay and the restore interval
            assign ac_fire = ac_pend_q[g] && ac_tmr_q[g] == TIMER_ZERO && ras_tmr_q[g] == TIMER_ZERO;

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    bank_st_q[g] <= SDCB_BANK_IDLE;
                    bank_tmr_q[g] <= TIMER_ZERO;
                    bank_rows_q[g*ROW_W +: ROW_W] <= ROW_RESET;
                end else if (open_go && sel) begin
                    bank_st_q[g] <= SDCB_BANK_OPEN;
                    bank_rows_q[g*ROW_W +: ROW_W] <= pins_q.addr[ROW_W-1:0];
                end else if (close_this || ac_fire) begin
                    bank_st_q[g] <= SDCB_BANK_CLOSING;
                    bank_tmr_q[g] <= cyc(PRECHARGE_PERIOD_CYC);
                end else if (bank_st_q[g] == SDCB_BANK_CLOSING) begin
                    if (bank_tmr_q[g] <= cyc(1)) begin
                        bank_st_q[g] <= SDCB_BANK_IDLE;
                        bank_tmr_q[g] <= TIMER_ZERO;
                    end else begin
                        bank_tmr_q[g] <= bank_tmr_q[g] - cyc(1);
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    ras_tmr_q[g] <= TIMER_ZERO;
                end else if (open_go && sel) begin
                    ras_tmr_q[g] <= cyc(ROW_ACTIVE_MIN_CYC);
                end else if (ras_tmr_q[g] != TIMER_ZERO) begin
                    ras_tmr_q[g] <= ras_tmr_q[g] - cyc(1);
                end
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    ac_pend_q[g] <= 1'b0;
                    ac_tmr_q[g] <= TIMER_ZERO;
                end else if (fetch_go && sel && ap_bit) begin
                    ac_pend_q[g] <= 1'b1;
                    ac_tmr_q[g] <= cyc(ADDITIVE_LATENCY + FETCH_TO_CLOSE_CYC - 1);
                end else if (store_go && sel && ap_bit) begin
                    // parked until the last beat lands, then write recovery
                    ac_pend_q[g] <= 1'b0;
                    ac_tmr_q[g] <= TIMER_ZERO;
                end else if (wr_ac_q && wr_last && wr_bank_q == BANK_W'(g)) begin
                    ac_pend_q[g] <= 1'b1;
                    ac_tmr_q[g] <= cyc(WRITE_RECOVERY_CYC);
                end else if (ac_fire || close_this) begin
                    ac_pend_q[g] <= 1'b0;
                end else if (ac_tmr_q[g] != TIMER_ZERO) begin
                    ac_tmr_q[g] <= ac_tmr_q[g] - cyc(1);
                end
            end

            assign bank_open_q[g] = bank_st_q[g] == SDCB_BANK_OPEN;
        end
    endgenerate

    // write burst: a new command during the burst does not cut it short
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            beats_left_q <= 4'h0;
            wr_bank_q <= 3'h0;
            wr_ac_q <= 1'b0;
            wr_ptr_q <= '0;
        end else if (store_go && beats_left_q == 4'h0) begin
            beats_left_q <= long_bit ? 4'h8 : 4'h4;
            wr_bank_q <= ba;
            wr_ac_q <= ap_bit;
            wr_ptr_q <= pins_q.addr[MEM_AW-1:0];
        end else if (beats_left_q != 4'h0) begin
            beats_left_q <= beats_left_q - 4'h1;
            wr_ptr_q <= wr_ptr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
            if (wr_last) begin
                wr_ac_q <= 1'b0;
            end
        end
    end

    // read burst beat counter and access report
    logic [BEAT_W-1:0] rd_left_q;
    logic [MEM_AW-1:0] rd_ptr_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rd_left_q <= 4'h0;
            rd_ptr_q <= '0;
            fetch_access_q <= '0;
        end else begin
            fetch_access_q.valid <= fetch_go;
            if (fetch_go) begin
                fetch_access_q.bank <= ba;
                fetch_access_q.row <= bank_rows_q[ba*ROW_W +: ROW_W];
                fetch_access_q.col <= pins_q.addr[COL_W-1:0];
                fetch_access_q.long_burst <= long_bit;
                rd_left_q <= long_bit ? 4'h8 : 4'h4;
                rd_ptr_q <= pins_q.addr[MEM_AW-1:0];
            end else if (rd_left_q != 4'h0) begin
                rd_left_q <= rd_left_q - 4'h1;
                rd_ptr_q <= rd_ptr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign burst_busy_q = (beats_left_q != 4'h0) || (rd_left_q != 4'h0);

    sdcb_byte_store #(
        .DEPTH(1 << MEM_AW),
        .AW(MEM_AW)
    ) u_store (
        .core_clk(core_clk),
        .wr_en(beats_left_q != 4'h0),
        .wr_mask(mask_q),
        .wr_addr(wr_ptr_q),
        .wr_data(data_q),
        .rd_addr(rd_ptr_q),
        .rd_data_q(fetch_data_q)
    );

    // mode load: taken only with every bank idle; the controller owns the wait after it
    logic all_idle;
    always_comb begin
        all_idle = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bank_st_q[i] != SDCB_BANK_IDLE) all_idle = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_value_q <= 16'h0000;
            mode_select_q <= 2'h0;
        end else if (live && cmd == SDCB_MODE_LOAD && all_idle) begin
            mode_value_q <= pins_q.addr;
            mode_select_q <= ba[1:0];
        end
    end

    // renew: one internal row per command, address inputs unused
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            renew_row_q <= 16'h0000;
        end else if ((live && cmd == SDCB_RENEW && all_idle)
                     || (cke_prev_q && !self_renew_q && cmd == SDCB_SELF_ENTER)) begin
            renew_row_q <= renew_row_q + 16'h0001;
        end
    end

    // self renew entry and exit; exit is clock enable rising
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            self_renew_q <= 1'b0;
            loop_enabled_q <= 1'b1;
            termination_enabled_q <= 1'b1;
        end else if (!self_renew_q && cke_prev_q && cmd == SDCB_SELF_ENTER && all_idle) begin
            self_renew_q <= 1'b1;
            loop_enabled_q <= 1'b0;
            termination_enabled_q <= 1'b0;
        end else if (self_renew_q && cke_q) begin
            self_renew_q <= 1'b0;
            loop_enabled_q <= 1'b1;
            termination_enabled_q <= 1'b1;
        end
    end

    // loop relock after exit; calibration may overlap it
    logic [9:0] cal_cnt_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lock_cnt_q <= 10'h000;
        end else if (self_renew_q && cke_q) begin
            lock_cnt_q <= SELF_EXIT_LOCK_CYC[9:0];
        end else if (lock_cnt_q != 10'h000) begin
            lock_cnt_q <= lock_cnt_q - 10'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cal_cnt_q <= 10'h000;
        end else if (live && cmd == SDCB_CAL && all_idle) begin
            cal_cnt_q <= ap_bit ? 10'h200 : 10'h040;
        end else if (cal_cnt_q != 10'h000) begin
            cal_cnt_q <= cal_cnt_q - 10'h001;
        end
    end

    assign calibrating_q = cal_cnt_q != 10'h000;
endmodule
`default_nettype wire

// file: verilog/sdcb_pkg.sv
// sdcb_pkg: shared constants and types for the dram command and bank control block
// assumes a single core clock at 40 MHz; all times are converted to cycles here
`default_nettype none
package sdcb_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ROW_W = 16;
    localparam int COL_W = 10;
    localparam int ADDR_W = 16;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int AUTOCLOSE_BIT = 10;
    localparam int CHOP_BIT = 12;
    localparam int BURST_LONG_BEATS = 8;
    localparam int BURST_SHORT_BEATS = 4;
    // times in picoseconds with the printed-style defaults chosen neutral
    localparam int PRECHARGE_PERIOD_PS = 13750;
    localparam int ROW_ACTIVE_MIN_PS = 35000;
    localparam int FETCH_TO_CLOSE_PS = 7500;
    localparam int WRITE_RECOVERY_PS = 15000;
    localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ROW_ACTIVE_MIN_CYC = (ROW_ACTIVE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FETCH_TO_CLOSE_CYC = (FETCH_TO_CLOSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SELF_EXIT_LOCK_CYC = 512;
    localparam int TIMER_W = 8;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;
    localparam logic [ROW_W-1:0] ROW_RESET = 16'h0000;

    typedef enum logic [3:0] {
        SDCB_IDLE_CYCLE = 4'h0,
        SDCB_UNSELECTED = 4'h1,
        SDCB_MODE_LOAD = 4'h2,
        SDCB_RENEW = 4'h3,
        SDCB_SELF_ENTER = 4'h4,
        SDCB_CLOSE = 4'h5,
        SDCB_ROW_OPEN = 4'h6,
        SDCB_STORE = 4'h7,
        SDCB_FETCH = 4'h8,
        SDCB_CAL = 4'h9
    } sdcb_cmd_t;

    typedef enum logic [1:0] {
        SDCB_BANK_IDLE = 2'h0,
        SDCB_BANK_OPEN = 2'h1,
        SDCB_BANK_CLOSING = 2'h2
    } sdcb_bank_st_t;

    typedef struct packed {
        logic chip_sel_n;
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_strobe_n;
        logic [BANK_W-1:0] bank_select_inputs;
        logic [ADDR_W-1:0] addr;
    } sdcb_cmd_pins_t;

    typedef struct packed {
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic long_burst;
    } sdcb_access_t;
endpackage
`default_nettype wire

// file: verilog/sdcb_decode.sv
// sdcb_decode: turns sampled strobe levels into a command code
// assumes inputs already synchronised to core_clk; purely combinational
`default_nettype none
module sdcb_decode
    import sdcb_pkg::*;
(
    input wire sdcb_cmd_pins_t pins,
    input wire logic cke_prev,
    input wire logic cke_now,
    output sdcb_cmd_t cmd
);
    always_comb begin
        if (pins.chip_sel_n) begin
            cmd = SDCB_UNSELECTED;
        end else begin
            case ({pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n})
                3'b000: cmd = SDCB_MODE_LOAD;
                3'b001: cmd = (cke_prev && !cke_now) ? SDCB_SELF_ENTER : SDCB_RENEW;
                3'b010: cmd = SDCB_CLOSE;
                3'b011: cmd = SDCB_ROW_OPEN;
                3'b100: cmd = SDCB_STORE;
                3'b101: cmd = SDCB_FETCH;
                3'b110: cmd = SDCB_CAL;
                3'b111: cmd = SDCB_IDLE_CYCLE;
                default: cmd = SDCB_IDLE_CYCLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: verilog/sdcb_byte_store.sv
// sdcb_byte_store: small byte array written beat by beat under a mask
// assumes one beat per core_clk; read data comes from a register
`default_nettype none
module sdcb_byte_store #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic wr_mask,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data_q
);
    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH != (1 << AW)) $error("depth must equal 2**aw");
    end

    always_ff @(posedge core_clk) begin
        // masked beats leave the location untouched
        if (wr_en && !wr_mask) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data_q <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// file: verif/sdcb_ctrl_model.sv
// sdcb_ctrl_model: behavioural memory controller turning a command request into pin levels
// assumes the bench changes the request on the falling edge of core_clk
`default_nettype none
module sdcb_ctrl_model
    import sdcb_pkg::*;
(
    input wire logic core_clk,
    input wire sdcb_cmd_t req_cmd,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_cke,
    output sdcb_cmd_pins_t cmd_pins,
    output logic clk_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [22:0] junk_q = 23'h5a5a5a;
    // deselected pins toggle each cycle so a stale level never passes for a command
    always_ff @(negedge core_clk) begin
        junk_q <= {junk_q[21:0], junk_q[22] ^ junk_q[17]};
    end
    always_comb begin
        clk_enable = req_cke;
        cmd_pins = {4'b0111, req_bank, req_addr};
        case (req_cmd)
            SDCB_UNSELECTED: cmd_pins = {1'b1, junk_q[21:0]};
            SDCB_MODE_LOAD: cmd_pins[22:19] = 4'b0000;
            SDCB_RENEW: cmd_pins[22:19] = 4'b0001;
            SDCB_SELF_ENTER: cmd_pins[22:19] = 4'b0001;
            SDCB_CLOSE: cmd_pins[22:19] = 4'b0010;
            SDCB_ROW_OPEN: cmd_pins[22:19] = 4'b0011;
            SDCB_STORE: cmd_pins[22:19] = 4'b0100;
            SDCB_FETCH: cmd_pins[22:19] = 4'b0101;
            SDCB_CAL: cmd_pins[22:19] = 4'b0110;
            default: cmd_pins[22:19] = 4'b0111;
        endcase
    end
endmodule
`default_nettype wire

// file: verif/sdcb_core_monitor.sv
// sdcb_core_monitor: port-level assertions for sdcb_core
// assumes the three-edge delay from pins to state outputs
`default_nettype none
module sdcb_core_monitor
    import sdcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire sdcb_cmd_pins_t cmd_pins,
    input wire logic clk_enable,
    input wire sdcb_access_t fetch_access_q,
    input wire logic [NUM_BANKS-1:0] bank_open_q,
    input wire logic [NUM_BANKS*ROW_W-1:0] bank_rows_q,
    input wire logic [ADDR_W-1:0] mode_value_q,
    input wire logic self_renew_q,
    input wire logic loop_enabled_q,
    input wire logic termination_enabled_q,
    input wire logic calibrating_q,
    input wire logic [15:0] renew_row_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    wire logic [3:0] strb = cmd_pins[22:19];
    wire logic close_go = strb == 4'b0010 && clk_enable;
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        open_cause_a: assert property ($rose(bank_open_q[b]) |-> $past(strb == 4'b0011 && clk_enable, 3)
            && $past(cmd_pins.bank_select_inputs, 3) == b) else $error("bank opened without a row open");
        open_row_a: assert property ($rose(bank_open_q[b]) |->
            bank_rows_q[b*ROW_W +: ROW_W] == $past(cmd_pins.addr, 3)) else $error("open row mismatch");
    end
    close_all_a: assert property (close_go && cmd_pins.addr[AUTOCLOSE_BIT] && $past(clk_enable)
        |-> ##3 bank_open_q == 8'h00) else $error("close all left a bank open");
    close_one_a: assert property (close_go && !cmd_pins.addr[AUTOCLOSE_BIT] && $past(clk_enable)
        |-> ##3 !bank_open_q[$past(cmd_pins.bank_select_inputs, 3)]) else $error("bank close missed");
    mode_load_a: assert property ($changed(mode_value_q) |-> $past(strb == 4'b0000 && clk_enable, 3)
        && mode_value_q == $past(cmd_pins.addr, 3)) else $error("mode value changed wrongly");
    renew_step_a: assert property ($changed(renew_row_q) |->
        renew_row_q == $past(renew_row_q) + 16'h0001) else $error("renew row did not step by one");
    self_quiet_a: assert property (self_renew_q |->
        !loop_enabled_q && !termination_enabled_q) else $error("loop or termination on in self renew");
    self_entry_a: assert property ($rose(self_renew_q) |-> $past(strb == 4'b0001 && !clk_enable, 3)
        && bank_open_q == 8'h00) else $error("self renew entered wrongly");
    fetch_cols_a: assert property (fetch_access_q.valid |->
        fetch_access_q.col == $past(cmd_pins.addr[COL_W-1:0], 3)
        && fetch_access_q.long_burst == $past(cmd_pins.addr[CHOP_BIT], 3)
        && bank_open_q[fetch_access_q.bank]) else $error("fetch fields wrong");
    cal_idle_a: assert property ($rose(calibrating_q) |->
        $past(bank_open_q) == 8'h00) else $error("calibration with open bank");
endmodule
bind sdcb_core sdcb_core_monitor i_sdcb_core_monitor (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_pins(cmd_pins), .clk_enable(clk_enable), .fetch_access_q(fetch_access_q),
    .bank_open_q(bank_open_q), .bank_rows_q(bank_rows_q), .mode_value_q(mode_value_q),
    .self_renew_q(self_renew_q), .loop_enabled_q(loop_enabled_q),
    .termination_enabled_q(termination_enabled_q), .calibrating_q(calibrating_q), .renew_row_q(renew_row_q));
`default_nettype wire

// file: verif/sdcb_core_tb.sv
// sdcb_core_tb: self-checking bench for the command and bank control block
// assumes the controller model drives the pins; the bench keeps a byte model of the array
`default_nettype none
module sdcb_core_tb
    import sdcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    sdcb_cmd_t req_cmd = SDCB_UNSELECTED;
    logic [2:0] req_bank = 3'h0;
    logic [15:0] req_addr = 16'h0000;
    logic req_cke = 1'b1;
    logic [7:0] store_data = 8'h00;
    logic byte_mask = 1'b0;
    sdcb_cmd_pins_t cmd_pins;
    logic clk_enable;
    sdcb_access_t fetch_access_q;
    logic [7:0] fetch_data_q;
    logic [7:0] bank_open_q;
    logic [127:0] bank_rows_q;
    logic [15:0] mode_value_q;
    logic [1:0] mode_select_q;
    logic self_renew_q, loop_enabled_q, termination_enabled_q, calibrating_q, burst_busy_q;
    logic [15:0] renew_row_q;
    int mismatches = 0;
    int check_count = 0;
    logic [7:0] exp_mem [256];
    logic [7:0] cap [24];
    logic [15:0] rows [8];

    sdcb_ctrl_model i_sdcb_ctrl_model (.core_clk(core_clk), .req_cmd(req_cmd), .req_bank(req_bank),
        .req_addr(req_addr), .req_cke(req_cke), .cmd_pins(cmd_pins), .clk_enable(clk_enable));
    sdcb_core #(.ADDITIVE_LATENCY(0), .MEM_AW(8)) i_sdcb_core (.core_clk(core_clk), .reset_n(reset_n),
        .cmd_pins(cmd_pins), .clk_enable(clk_enable), .store_data(store_data), .byte_mask(byte_mask),
        .fetch_access_q(fetch_access_q), .fetch_data_q(fetch_data_q), .bank_open_q(bank_open_q),
        .bank_rows_q(bank_rows_q), .mode_value_q(mode_value_q), .mode_select_q(mode_select_q),
        .self_renew_q(self_renew_q), .loop_enabled_q(loop_enabled_q),
        .termination_enabled_q(termination_enabled_q), .calibrating_q(calibrating_q),
        .renew_row_q(renew_row_q), .burst_busy_q(burst_busy_q));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp_v);
        check_count++;
        if (seen !== exp_v) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp_v);
        end
    endtask

    task automatic send(input sdcb_cmd_t c, input logic [2:0] b, input logic [15:0] a);
        @(negedge core_clk);
        req_cmd = c;
        req_bank = b;
        req_addr = a;
    endtask

    task automatic idle(input int n);
        repeat (n) send(SDCB_IDLE_CYCLE, req_bank, req_addr);
    endtask

    // beats follow the command one per cycle; beats past a short burst must not land
    task automatic store(input logic [2:0] b, input logic [7:0] col, input logic lng, input logic ac,
                         input logic [63:0] d, input logic [7:0] m);
        send(SDCB_STORE, b, {3'h0, lng, 1'b0, ac, 2'h0, col});
        for (int k = 0; k < 8; k++) begin
            @(negedge core_clk);
            if (k == 0)
                req_cmd = SDCB_IDLE_CYCLE;
            store_data = d[8*k +: 8];
            byte_mask = m[k];
            if (!m[k] && (lng || k < 4))
                exp_mem[8'(col + k)] = d[8*k +: 8];
        end
        check(bank_open_q[b], 1'b1);
        idle(14);
    endtask

    function automatic logic seq_ok(input int s, input logic [7:0] col);
        for (int k = 0; k < 8; k++)
            if (cap[s + k] !== exp_mem[8'(col + k)])
                return 1'b0;
        return 1'b1;
    endfunction

    // read latency is not fixed at the ports, so the burst is searched for in a window
    task automatic fetch(input logic [2:0] b, input logic [7:0] col, input logic ac);
        logic hit;
        send(SDCB_FETCH, b, {3'h0, 1'b1, 1'b0, ac, 2'h0, col});
        for (int i = 0; i < 24; i++) begin
            @(negedge core_clk);
            if (i == 0)
                req_cmd = SDCB_IDLE_CYCLE;
            cap[i] = fetch_data_q;
            if (i == 2)
                check({fetch_access_q.valid, fetch_access_q.bank, fetch_access_q.row}, {1'b1, b, rows[b]});
        end
        hit = 1'b0;
        for (int s = 0; s <= 16; s++)
            if (seq_ok(s, col))
                hit = 1'b1;
        check(hit, 1'b1);
    endtask

    initial begin
        logic [15:0] a;
        logic [7:0] col;
        void'($urandom(77));
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        idle(4);
        check({bank_open_q, self_renew_q, loop_enabled_q, termination_enabled_q}, 11'h003);
        a = 16'($urandom);
        send(SDCB_MODE_LOAD, 3'h2, a);
        idle(4);
        check({mode_select_q, mode_value_q}, {2'h2, a});
        for (int b = 0; b < 4; b++) begin
            rows[b] = 16'($urandom);
            send(SDCB_ROW_OPEN, 3'(b), rows[b]);
            idle(3);
        end
        send(SDCB_UNSELECTED, 3'h5, 16'h0);
        send(SDCB_IDLE_CYCLE, 3'h5, 16'hffff);
        idle(4);
        check({bank_open_q, bank_rows_q[63:0]}, {8'h0f, rows[3], rows[2], rows[1], rows[0]});
        col = 8'($urandom_range(247, 0));
        store(3'h2, col, 1'b1, 1'b0, {$urandom, $urandom}, 8'h00);
        store(3'h2, col, 1'b1, 1'b0, {$urandom, $urandom}, 8'($urandom));
        store(3'h2, col, 1'b0, 1'b0, {$urandom, $urandom}, 8'h00);
        fetch(3'h2, col, 1'b0);
        check(bank_open_q[2], 1'b1);
        store(3'h1, col, 1'b1, 1'b1, {$urandom, $urandom}, 8'h00);
        check(bank_open_q[1], 1'b0);
        fetch(3'h3, col, 1'b1);
        check(bank_open_q, 8'h05);
        send(SDCB_CLOSE, 3'h0, 16'h0000);
        idle(4);
        send(SDCB_CLOSE, 3'h3, 16'h0000);
        idle(4);
        check(bank_open_q, 8'h04);
        send(SDCB_CLOSE, 3'h2, 16'h0000);
        idle(2);
        rows[2] = 16'($urandom);
        send(SDCB_ROW_OPEN, 3'h2, rows[2]);
        idle(4);
        check({bank_open_q, bank_rows_q[47:32]}, {8'h04, rows[2]});
        send(SDCB_CLOSE, 3'($urandom), 16'h0400);
        idle(4);
        check(bank_open_q, 8'h00);
        repeat (3) send(SDCB_RENEW, 3'($urandom), 16'($urandom));
        idle(4);
        check(renew_row_q, 16'h0003);
        send(SDCB_ROW_OPEN, 3'h6, rows[0]);
        idle(3);
        send(SDCB_CAL, 3'h0, 16'h0400);
        idle(4);
        check(calibrating_q, 1'b0);
        send(SDCB_CLOSE, 3'h0, 16'h0400);
        idle(3);
        send(SDCB_CAL, 3'h0, 16'h0400);
        idle(4);
        check(calibrating_q, 1'b1);
        idle(520);
        check(calibrating_q, 1'b0);
        send(SDCB_CAL, 3'h0, 16'h0000);
        idle(4);
        check(calibrating_q, 1'b1);
        idle(70);
        check(calibrating_q, 1'b0);
        send(SDCB_SELF_ENTER, 3'h0, 16'h0000);
        req_cke = 1'b0;
        repeat (6) send(SDCB_UNSELECTED, 3'h0, 16'h0000);
        check({self_renew_q, loop_enabled_q, termination_enabled_q}, 3'b100);
        @(negedge core_clk);
        req_cke = 1'b1;
        idle(6);
        check({self_renew_q, termination_enabled_q}, 2'b01);
        send(SDCB_CAL, 3'h0, 16'h0000);
        idle(4);
        check(calibrating_q, 1'b1);
        idle(512);
        check(loop_enabled_q, 1'b1);
        complete_run();
    end

    initial begin
        repeat (6000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
